// ---- hw/jac_cfg_decode.sv ----
`timescale 1ns/10ps
module jac_cfg_decode
(
  // configuration bits
  input  wire logic             i_cfg_hi,
  input  wire logic             i_cfg_lo,
  // decoded mode
  output jac_pkg::jac_mode_t    o_mode,
  output logic [5:0]            o_depth
);

  // undefined codes fall back to off until clarified
  assign o_mode  = (!i_cfg_lo && !i_cfg_hi) ? jac_pkg::JAC_D16 :
                   (!i_cfg_lo &&  i_cfg_hi) ? jac_pkg::JAC_D32 :
                   jac_pkg::JAC_OFF;
  assign o_depth = (o_mode == jac_pkg::JAC_D16) ? jac_pkg::DEPTH_16 :
                   (o_mode == jac_pkg::JAC_D32) ? jac_pkg::DEPTH_32 :
                   jac_pkg::DEPTH_NONE;

endmodule

// ---- hw/jac_channel.sv ----
// Overview of operation
// - zero-to-one write on bit 3 resets fifo
// - reset returns read/write pointers home
// - reset flushes fifo contents, leaves empty
// - bits 2 and 0 select enable, depth
// - both zero gives sixteen-bit fifo depth
// - lo zero, hi one gives thirty-two depth
`timescale 1ns/10ps
module jac_channel
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // register port
  input  wire logic             i_wr,
  input  wire logic [7:0]       i_wdata,
  output logic [7:0]            o_rdata,
  // fifo data path
  input  wire jac_pkg::jac_bit_t i_in,
  input  wire logic             i_rd,
  output jac_pkg::jac_bit_t     o_out,
  // status
  output jac_pkg::jac_stat_t    o_stat,
  output logic                  o_flush
);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [7:0]           ctrl;
  logic [7:0]           next_ctrl;
  logic                 rst_rise;
  jac_pkg::jac_mode_t   mode;
  logic [5:0]           depth;
  logic                 enabled;

  // reserved bits 7..4 read as zero
  assign next_ctrl = i_wr ? (i_wdata & jac_pkg::CTRL_WMASK) : ctrl;

  logic                 wr_rst_set;
  logic                 held_rst_set;

  assign wr_rst_set   = i_wr && i_wdata[jac_pkg::BIT_FIFO_RST];
  assign held_rst_set = ctrl[jac_pkg::BIT_FIFO_RST];
  // only a true 0->1 edge fires; bit must be cleared to re-arm
  assign rst_rise     = wr_rst_set && !held_rst_set;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ctrl <= jac_pkg::CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  jac_cfg_decode u_dec
  (
    .i_cfg_hi (ctrl[jac_pkg::BIT_CFG_HI]),
    .i_cfg_lo (ctrl[jac_pkg::BIT_CFG_LO]),
    .o_mode   (mode),
    .o_depth  (depth)
  );

  assign enabled = (mode != jac_pkg::JAC_OFF);

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic                         cfg_hi_moves;
  logic                         cfg_lo_moves;
  logic                         cfg_change;
  logic                         clr;

  // a depth change also clears, so pointers never exceed the window
  assign cfg_hi_moves = next_ctrl[jac_pkg::BIT_CFG_HI]
                        != ctrl[jac_pkg::BIT_CFG_HI];
  assign cfg_lo_moves = next_ctrl[jac_pkg::BIT_CFG_LO]
                        != ctrl[jac_pkg::BIT_CFG_LO];
  assign cfg_change   = i_wr && (cfg_hi_moves || cfg_lo_moves);
  assign clr          = rst_rise || cfg_change;

  // ---------------------------------------------------------------
  // fifo handshake
  // ---------------------------------------------------------------
  logic [5:0]                   level;
  logic                         full;
  logic                         empty;
  logic                         do_wr;
  logic                         do_rd;

  // disabled mode has depth zero, so full would shadow empty
  assign full  = enabled && (level == depth);
  assign empty = (level == jac_pkg::CNT_ZERO);
  // requests in a clearing cycle are dropped, not queued
  assign do_wr = enabled && i_in.valid && !full && !clr;
  assign do_rd = enabled && i_rd && !empty && !clr;

  // ---------------------------------------------------------------
  // fifo pointers
  // ---------------------------------------------------------------
  logic [4:0]                   wptr;
  logic [4:0]                   rptr;
  logic [4:0]                   last;
  logic [4:0]                   next_wptr;
  logic [4:0]                   next_rptr;

  // pointers wrap at the selected depth, not at the array end
  assign last      = 5'(depth - 6'h01);
  assign next_wptr = (wptr == last) ? jac_pkg::PTR_HOME
                                    : 5'(wptr + 5'h01);
  assign next_rptr = (rptr == last) ? jac_pkg::PTR_HOME
                                    : 5'(rptr + 5'h01);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || clr)
      wptr <= jac_pkg::PTR_HOME;
    else if (do_wr)
      wptr <= next_wptr;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || clr)
      rptr <= jac_pkg::PTR_HOME;
    else if (do_rd)
      rptr <= next_rptr;
  end

  // ---------------------------------------------------------------
  // fifo level
  // ---------------------------------------------------------------
  logic [5:0]                   next_level;

  // a push and a pop in one cycle leave the level where it is
  assign next_level = (do_wr && !do_rd) ? 6'(level + 6'h01) :
                      (do_rd && !do_wr) ? 6'(level - 6'h01) :
                      level;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || clr)
      level <= jac_pkg::CNT_ZERO;
    else
      level <= next_level;
  end

  // ---------------------------------------------------------------
  // fifo storage
  // ---------------------------------------------------------------
  logic [jac_pkg::FIFO_MAX-1:0] mem;
  logic                         head;

  // flushed bits are zeroed so a stale head never leaks out
  assign head = mem[rptr];

  always_ff @(posedge i_clk)
  begin
    if (i_rst || clr)
      mem <= '0;
    else if (do_wr)
      mem[wptr] <= i_in.data;
  end

  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  jac_pkg::jac_stat_t           next_stat;
  jac_pkg::jac_bit_t            next_out;

  // status shows the flush in the clearing cycle, not one late
  assign next_stat = '{enable: enabled,
                       depth:  depth,
                       level:  clr ? jac_pkg::CNT_ZERO : level,
                       empty:  clr || empty,
                       full:   !clr && full};
  assign next_out  = '{valid: do_rd,
                       data:  head};

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // readback mirrors ctrl, so a write shows on the next cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= jac_pkg::CTRL_RESET;
    else
      o_rdata <= next_ctrl;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_out <= '0;
    else
      o_out <= next_out;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_stat <= '0;
    else
      o_stat <= next_stat;
  end

  // one pulse marks both causes of a clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_flush <= 1'b0;
    else
      o_flush <= clr;
  end

endmodule

// ---- hw/jac_pkg.sv ----
package jac_pkg;

  // ---------------------------------------------------------------
  // register layout
  // ---------------------------------------------------------------
  localparam int        REG_W        = 8;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int        BIT_FIFO_RST = 3;
  localparam int        BIT_CFG_HI   = 2;
  localparam int        BIT_CFG_LO   = 0;
  localparam logic [7:0] CTRL_WMASK  = 8'h0f;

  // ---------------------------------------------------------------
  // fifo geometry
  // ---------------------------------------------------------------
  localparam int        FIFO_MAX     = 32;
  localparam int        PTR_W        = 5;
  localparam logic [5:0] DEPTH_16    = 6'h10;
  localparam logic [5:0] DEPTH_32    = 6'h20;
  localparam logic [5:0] DEPTH_NONE  = 6'h00;
  localparam logic [4:0] PTR_HOME    = 5'h00;
  localparam logic [5:0] CNT_ZERO    = 6'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    JAC_OFF   = 3'b001,
    JAC_D16   = 3'b010,
    JAC_D32   = 3'b100
  } jac_mode_t;

  typedef struct packed {
    logic       valid;
    logic       data;
  } jac_bit_t;

  typedef struct packed {
    logic       enable;
    logic [5:0] depth;
    logic [5:0] level;
    logic       empty;
    logic       full;
  } jac_stat_t;

endpackage

// ---- tb/jac_channel_properties.sv ----
`timescale 1ns/10ps
module jac_channel_properties
(
  // watched ports
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_wr,
  input wire logic [7:0]         i_wdata,
  input wire logic [7:0]         o_rdata,
  input wire jac_pkg::jac_stat_t o_stat,
  input wire logic               o_flush
);
  // ---------------------------------------------------------------
  // write steps
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence set_edge;
    i_wr && i_wdata[3] && !o_rdata[3];
  endsequence
  sequence set_again;
    i_wr && i_wdata[3] && o_rdata[3] && i_wdata[2] == o_rdata[2]
      && i_wdata[0] == o_rdata[0];
  endsequence
  // three samples: status trails the readback by a cycle
  sequence cfg_held(hi, lo);
    (o_rdata[2] == hi && o_rdata[0] == lo) [*3];
  endsequence
  a_reset_clears:
  assert property (set_edge |-> ##[1:2] (o_flush && o_stat.empty
    && o_stat.level == 6'h00)) else $error("reset edge did not clear");
  a_no_rearm:
  assert property (set_again |-> ##1 !o_flush
    ##1 (!o_flush || $past(i_wr)))
    else $error("flush without a rising reset bit");
  a_flush_cause:
  assert property (o_flush |-> $past(i_wr) || $past(i_wr, 2))
    else $error("flush without a write");
  a_cfg_flush:
  assert property (i_wr && (i_wdata[2] != o_rdata[2] || i_wdata[0]
    != o_rdata[0]) |-> ##[1:2] o_flush) else $error("cfg change kept data");
  a_depth_sixteen:
  assert property (cfg_held(1'b0, 1'b0) |-> o_stat.enable
    && o_stat.depth == 6'h10) else $error("depth not sixteen");
  a_depth_wide:
  assert property (cfg_held(1'b1, 1'b0) |-> o_stat.enable
    && o_stat.depth == 6'h20) else $error("depth not thirty-two");
  a_undef_off:
  assert property (o_rdata[0] [*3] |-> !o_stat.enable)
    else $error("undefined code left attenuator on");
endmodule
bind jac_channel jac_channel_properties u_props (.i_clk(i_clk),
  .i_rst(i_rst), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_stat(o_stat), .o_flush(o_flush));

// ---- tb/jitter_atten_channel_control_tb_top.sv ----
`timescale 1ns/10ps
module jitter_atten_channel_control_tb_top;
  logic               i_clk   = 1'b0;
  logic               i_rst   = 1'b1;
  logic               i_wr    = 1'b0;
  logic [7:0]         i_wdata = 8'h00;
  logic               i_rd    = 1'b0;
  jac_pkg::jac_bit_t  i_in    = '0;
  logic [7:0]         o_rdata;
  jac_pkg::jac_bit_t  o_out;
  jac_pkg::jac_stat_t o_stat;
  logic               o_flush;
  int                 n_mismatch = 0;
  int                 comparisons = 0;
  int                 flushes = 0;
  logic [7:0]         got;
  logic [7:0]         codes [3] = '{8'h01, 8'h05, 8'h00};
  always #20 i_clk = ~i_clk;
  // pulse is one cycle wide, so count it rather than sample it
  always @(negedge i_clk) if (o_flush === 1'b1) flushes++;
  jac_channel DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_in(i_in), .i_rd(i_rd),
    .o_out(o_out), .o_stat(o_stat), .o_flush(o_flush));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge i_clk);
    i_wr = 1'b1;
    i_wdata = d;
    @(negedge i_clk);
    i_wr = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic push(input int n, input logic d);
    i_in = '{valid: 1'b1, data: d};
    repeat (n) @(negedge i_clk);
    i_in = '0;
    repeat (2) @(negedge i_clk);
  endtask
  // data is masked by valid so an empty pop reads as zero
  task automatic pop(output logic [7:0] seen);
    @(negedge i_clk);
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    seen = {6'h00, o_out.valid, o_out.data & o_out.valid};
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    chk({o_stat.enable, 1'b0, o_stat.depth}, 8'h90);
    push(5, 1'b1);
    chk({2'b0, o_stat.level}, 8'h05);
    pop(got);
    chk(got, 8'h03);
    pop(got);
    chk(got, 8'h03);
    wr(8'h08);
    chk({2'b0, o_stat.level}, 8'h00);
    chk({7'h0, o_stat.empty}, 8'h01);
    chk(flushes[7:0], 8'h01);
    pop(got);
    chk(got, 8'h00);
    push(1, 1'b0);
    push(1, 1'b1);
    pop(got);
    chk(got, 8'h02);
    pop(got);
    chk(got, 8'h03);
    wr(8'h08);
    chk(flushes[7:0], 8'h01);
    wr(8'h00);
    wr(8'h08);
    chk(flushes[7:0], 8'h02);
    wr(8'h04);
    chk({o_stat.enable, 1'b0, o_stat.depth}, 8'ha0);
    push(34, 1'b1);
    chk({o_stat.full, 1'b0, o_stat.level}, 8'ha0);
    foreach (codes[k])
    begin
      wr(codes[k]);
      chk(o_rdata, codes[k]);
      chk({7'h0, o_stat.enable}, {7'h0, ~codes[k][0]});
    end
    end_sim();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    end_sim();
  end
endmodule
